/* File: common/rre_map.svh */
// Purpose: constants for the return and rotate execution block
// Assumes: 16-bit opcodes, 8-bit data path
// Notes:   definitions only
`ifndef RRE_MAP_SVH
`define RRE_MAP_SVH
`define RRE_RET_MASK      16'hFFFE
`define RRE_RET_MATCH     16'h0012
`define RRE_ROT_MASK      16'hFC00
`define RRE_ROT_MATCH     16'h3400
`define RRE_SHADOW_BIT    0
`define RRE_DEST_BIT      9
`define RRE_ACCESS_BIT    8
`define RRE_ILO_LIMIT     8'h5F
`define RRE_FLAG_C        0
`define RRE_FLAG_Z        2
`define RRE_FLAG_N        4
`define RRE_ACC_SPLIT     8'h60
`define RRE_ACC_HI_BANK   4'hF
`define RRE_ACC_LO_BANK   4'h0
`define RRE_PC_RST        21'h00000
`define RRE_BYTE_RST      8'h00
`endif

/* File: common/rre_pkg.sv */
// Purpose: types for the return and rotate execution block
// Assumes: nothing
// Notes:   one-hot sequencing states
package rre_pkg;
   typedef enum logic [1:0] {
      RRE_ST_EXEC = 2'b01,
      RRE_ST_NOP  = 2'b10
   } rre_state_type;
endpackage

/* File: src/rre_core.sv */
// Purpose: executes return-from-subroutine and rotate-left-through-carry
// Assumes: file memory outside; reads combinational, writes on the strobe
// Notes:   one instruction accepted per cycle when instr_ready is high
//
// Decided for this implementation: strobed register access and the address map.
`include "rre_map.svh"
`timescale 1ns/1ps
`default_nettype none
module rre_core #(
   parameter int ADDR_W = 12
) (
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   input  wire logic              instr_valid,
   input  wire logic [15:0]       instr_word,
   output logic                   instr_ready,
   output logic                   instr_illegal,
   input  wire logic              ext_set_en,
   input  wire logic [ADDR_W-1:0] fsr2_base,
   input  wire logic [20:0]       stack_top_value,
   output logic                   stack_pop,
   output logic [20:0]            pc_q,
   input  wire logic [7:0]        shadow_working_reg,
   input  wire logic [7:0]        shadow_flags_reg,
   input  wire logic [7:0]        shadow_bank_select,
   input  wire logic [7:0]        pc_upper_latch,
   input  wire logic [7:0]        pc_high_latch,
   output logic [7:0]             working_q,
   output logic [7:0]             flags_q,
   output logic [7:0]             bank_select_reg,
   output logic [ADDR_W-1:0]      file_addr,
   input  wire logic [7:0]        file_rdata,
   output logic [7:0]             file_wdata_q,
   output logic [ADDR_W-1:0]      file_waddr_q,
   output logic                   file_we_q,
   output logic                   indexed_mode
);
   ////////////////////////////////////////////////////////////////////
   // decode
   rre_pkg::rre_state_type state_q;
   rre_pkg::rre_state_type state_d;
   logic [20:0]            pc_d;
   logic [7:0]             working_d;
   logic [7:0]             flags_d;
   logic [7:0]             bank_sel_q;
   logic [7:0]             bank_sel_d;
   logic                   file_we_d;
   logic [7:0]             file_wdata_d;
   logic [ADDR_W-1:0]      file_waddr_d;
   logic [7:0]             rot_flags;

   wire       is_exec     = (state_q == rre_pkg::RRE_ST_EXEC);
   wire       take        = instr_valid && is_exec;
   wire       is_ret      = ((instr_word & `RRE_RET_MASK) == `RRE_RET_MATCH);
   wire       is_rot      = ((instr_word & `RRE_ROT_MASK) == `RRE_ROT_MATCH);
   wire       shadow_sel  = instr_word[`RRE_SHADOW_BIT];
   wire       dest_file   = instr_word[`RRE_DEST_BIT];
   wire       bank_by_sel = instr_word[`RRE_ACCESS_BIT];
   wire [7:0] f_field     = instr_word[7:0];
   wire       do_rot      = take && is_rot;
   wire       do_ret      = take && is_ret;
   wire       ret_shadow  = do_ret && shadow_sel;
   wire       rot_to_w    = do_rot && !dest_file;
   wire       rot_to_f    = do_rot && dest_file;

   assign instr_ready     = is_exec;
   assign bank_select_reg = bank_sel_q;
   assign stack_pop       = do_ret;
   assign instr_illegal   = take && !is_ret && !is_rot;

   ////////////////////////////////////////////////////////////////////
   // file address generation
   wire              ilo_hit  = !bank_by_sel && ext_set_en && (f_field <= `RRE_ILO_LIMIT);
   wire [ADDR_W-1:0] f_ext    = ADDR_W'(f_field);
   wire [ADDR_W-1:0] ilo_adr  = fsr2_base + f_ext;
   wire [ADDR_W-1:0] sel_adr  = {bank_sel_q[ADDR_W-9:0], f_field};
   wire              acc_low  = (f_field < `RRE_ACC_SPLIT);
   wire [3:0]        acc_bank = acc_low ? `RRE_ACC_LO_BANK : `RRE_ACC_HI_BANK;
   wire [ADDR_W-1:0] acc_adr  = ADDR_W'({acc_bank, f_field});

   assign indexed_mode = is_rot && ilo_hit;
   assign file_addr    = ilo_hit ? ilo_adr : (bank_by_sel ? sel_adr : acc_adr);

   ////////////////////////////////////////////////////////////////////
   // rotate datapath
   wire [7:0] rot_res = {file_rdata[6:0], flags_q[`RRE_FLAG_C]};

   always_comb begin
      rot_flags = flags_q;
      rot_flags[`RRE_FLAG_C] = file_rdata[7];
      rot_flags[`RRE_FLAG_N] = rot_res[7];
      rot_flags[`RRE_FLAG_Z] = (rot_res == `RRE_BYTE_RST);
   end

   // latches are inputs only: nothing here writes them
   wire unused_latches = ^{pc_upper_latch, pc_high_latch};

   ////////////////////////////////////////////////////////////////////
   // sequencing
   always_comb begin
      case (state_q)
         rre_pkg::RRE_ST_EXEC: state_d = do_ret ? rre_pkg::RRE_ST_NOP : rre_pkg::RRE_ST_EXEC;
         rre_pkg::RRE_ST_NOP:  state_d = rre_pkg::RRE_ST_EXEC;
         default:              state_d = rre_pkg::RRE_ST_EXEC;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // next values
   // program counter moves only on a taken return
   always_comb begin
      pc_d = pc_q;
      if (do_ret) begin
         pc_d = stack_top_value;
      end
   end

   always_comb begin
      working_d = working_q;
      if (ret_shadow) begin
         working_d = shadow_working_reg;
      end else if (rot_to_w) begin
         working_d = rot_res;
      end
   end

   // a plain return leaves the flags alone
   always_comb begin
      flags_d = flags_q;
      if (ret_shadow) begin
         flags_d = shadow_flags_reg;
      end else if (do_rot) begin
         flags_d = rot_flags;
      end
   end

   always_comb begin
      bank_sel_d = bank_sel_q;
      if (ret_shadow) begin
         bank_sel_d = shadow_bank_select;
      end
   end

   // write port: one-cycle strobe after a rotate to the file is taken
   always_comb begin
      file_we_d    = rot_to_f;
      file_wdata_d = file_wdata_q;
      file_waddr_d = file_waddr_q;
      if (do_rot) begin
         file_wdata_d = rot_res;
         file_waddr_d = file_addr;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state_q <= rre_pkg::RRE_ST_EXEC;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pc_q <= `RRE_PC_RST;
      end else begin
         pc_q <= pc_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         working_q <= `RRE_BYTE_RST;
      end else begin
         working_q <= working_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         flags_q <= `RRE_BYTE_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         bank_sel_q <= `RRE_BYTE_RST;
      end else begin
         bank_sel_q <= bank_sel_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         file_we_q <= 1'b0;
      end else begin
         file_we_q <= file_we_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         file_wdata_q <= `RRE_BYTE_RST;
      end else begin
         file_wdata_q <= file_wdata_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         file_waddr_q <= '0;
      end else begin
         file_waddr_q <= file_waddr_d;
      end
   end
endmodule
`default_nettype wire

/* File: verif/rre_checker.sv */
// Purpose: port-level properties of rre_core
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every rre_core instance
`timescale 1ns/1ps
`default_nettype none
module rre_checker (
   input wire logic        core_clk,
   input wire logic        rst_b,
   input wire logic        instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic        instr_ready,
   input wire logic        ext_set_en,
   input wire logic [20:0] stack_top_value,
   input wire logic        stack_pop,
   input wire logic [20:0] pc_q,
   input wire logic [7:0]  working_q,
   input wire logic [7:0]  flags_q,
   input wire logic [7:0]  file_rdata,
   input wire logic [7:0]  file_wdata_q,
   input wire logic        file_we_q,
   input wire logic        indexed_mode,
   input wire logic [7:0]  shadow_working_reg,
   input wire logic [7:0]  shadow_flags_reg,
   input wire logic [7:0]  shadow_bank_select,
   input wire logic [7:0]  bank_select_reg
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   wire       ret = instr_valid && instr_ready && instr_word[15:1] == 15'h0009;
   wire       rot = instr_valid && instr_ready && instr_word[15:10] == 6'h0D;
   // rotate result as the design should form it
   wire [7:0] res = {file_rdata[6:0], flags_q[0]};
   ////////////////////////////////////////////////////////////////
   property p_pop; ret |-> stack_pop; endproperty
   a_pop: assert property (p_pop) else $error("no pop on return");
   property p_pc; ret |=> pc_q == $past(stack_top_value); endproperty
   a_pc: assert property (p_pc) else $error("pc not loaded");
   property p_keep; ret && !instr_word[0] |=> $stable(working_q) && $stable(flags_q)
      && $stable(bank_select_reg); endproperty
   a_keep: assert property (p_keep) else $error("return altered regs");
   property p_dead; ret |=> !instr_ready ##1 instr_ready; endproperty
   a_dead: assert property (p_dead) else $error("return timing");
   property p_car; rot |=> flags_q[0] == $past(file_rdata[7]) && flags_q[4] == $past(res[7])
      && flags_q[2] == ($past(res) == 8'h00); endproperty
   a_car: assert property (p_car) else $error("rotate flags");
   property p_wr; rot && instr_word[9] |=> file_we_q && file_wdata_q == $past(res); endproperty
   a_wr: assert property (p_wr) else $error("file write");
   property p_w; rot && !instr_word[9] |=> !file_we_q && working_q == $past(res); endproperty
   a_w: assert property (p_w) else $error("working write");
   property p_idx; rot && !instr_word[8] && ext_set_en && instr_word[7:0] <= 8'h5F |-> indexed_mode; endproperty
   a_idx: assert property (p_idx) else $error("indexed mode");
   property p_shad; ret && instr_word[0] |=> working_q == $past(shadow_working_reg)
      && flags_q == $past(shadow_flags_reg) && bank_select_reg == $past(shadow_bank_select); endproperty
   a_shad: assert property (p_shad) else $error("shadow restore");
   c_ret_s: cover property (ret && instr_word[0]);
   c_rot_f: cover property (rot && instr_word[9]);
   c_idx: cover property (rot && indexed_mode);
endmodule
bind rre_core rre_checker u_chk (.core_clk(core_clk), .rst_b(rst_b), .instr_valid(instr_valid),
   .instr_word(instr_word), .instr_ready(instr_ready), .ext_set_en(ext_set_en), .stack_top_value(stack_top_value),
   .stack_pop(stack_pop), .pc_q(pc_q), .working_q(working_q), .flags_q(flags_q), .file_rdata(file_rdata),
   .file_wdata_q(file_wdata_q), .file_we_q(file_we_q), .indexed_mode(indexed_mode),
   .shadow_working_reg(shadow_working_reg), .shadow_flags_reg(shadow_flags_reg),
   .shadow_bank_select(shadow_bank_select), .bank_select_reg(bank_select_reg));
`default_nettype wire

/* File: verif/tb.sv */
// Purpose: directed bench for rre_core
// Assumes: 25 MHz core_clk
// Notes:   checks follow each instruction
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        core_clk = 0, rst_b = 0, instr_valid = 0, ext_set_en = 0;
   logic [15:0] instr_word = 16'h0000;
   logic [20:0] stack_top_value = 21'h1ABCD;
   logic [7:0]  sw = 8'h5A, sf = 8'h01, sb = 8'h03, file_rdata = 8'h00;
   logic [7:0]  working_q, flags_q, bank_select_reg, file_wdata_q;
   logic [20:0] pc_q;
   logic [11:0] file_addr, addr, file_waddr_q;
   logic        instr_ready, idx, file_we_q, indexed_mode, instr_illegal, stack_pop, ill, pop;
   int          err_total = 0, comparisons = 0;
   always #20 core_clk = ~core_clk;
   rre_core DUT (.core_clk(core_clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr_word(instr_word),
      .instr_ready(instr_ready), .instr_illegal(instr_illegal), .ext_set_en(ext_set_en), .fsr2_base(12'h100),
      .stack_top_value(stack_top_value), .stack_pop(stack_pop), .pc_q(pc_q), .shadow_working_reg(sw),
      .shadow_flags_reg(sf), .shadow_bank_select(sb), .pc_upper_latch(8'h00), .pc_high_latch(8'h00),
      .working_q(working_q), .flags_q(flags_q), .bank_select_reg(bank_select_reg), .file_addr(file_addr),
      .file_rdata(file_rdata), .file_wdata_q(file_wdata_q), .file_waddr_q(file_waddr_q), .file_we_q(file_we_q),
      .indexed_mode(indexed_mode));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (e !== g) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // one instruction; decode outputs captured 1 ns after the instruction is driven
   task automatic run(input logic [15:0] w, input logic [7:0] rd);
      @(posedge core_clk);
      instr_valid <= 1'h1;
      instr_word  <= w;
      file_rdata  <= rd;
      #1 idx = indexed_mode;
      addr = file_addr;
      ill = instr_illegal;
      pop = stack_pop;
      @(posedge core_clk);
      instr_valid <= 1'h0;
      #1;
   endtask
   task automatic tally_and_finish;
      if (err_total == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge core_clk);
      rst_b <= 1'h1;
      run(16'h0013, 8'h00);
      chk("pop", 32'h1, pop);
      chk("pc", 32'h1ABCD, pc_q);
      chk("w", 32'h5A, working_q);
      chk("flags", 32'h01, flags_q);
      chk("bsr", 32'h03, bank_select_reg);
      chk("ready", 32'h0, instr_ready);
      run(16'h3710, 8'h80);
      chk("addr", 32'h310, addr);
      chk("we", 32'h1, file_we_q);
      chk("wdata", 32'h01, file_wdata_q);
      chk("waddr", 32'h310, file_waddr_q);
      chk("flags", 32'h01, flags_q);
      run(16'h3510, 8'hE6);
      chk("w", 32'hCD, working_q);
      chk("flags", 32'h11, flags_q);
      chk("we", 32'h0, file_we_q);
      @(posedge core_clk);
      stack_top_value <= 21'h00042;
      sw <= 8'h77;
      run(16'h0012, 8'h00);
      chk("pc", 32'h42, pc_q);
      chk("w", 32'hCD, working_q);
      chk("flags", 32'h11, flags_q);
      chk("bsr", 32'h03, bank_select_reg);
      @(posedge core_clk);
      ext_set_en <= 1'h1;
      run(16'h3460, 8'h00);
      chk("idx", 32'h0, idx);
      chk("addr", 32'hF60, addr);
      chk("flags", 32'h00, flags_q);
      run(16'h345F, 8'h80);
      chk("idx", 32'h1, idx);
      chk("flags", 32'h05, flags_q);
      chk("w", 32'h00, working_q);
      chk("addr", 32'h15F, addr);
      run(16'hFFFF, 8'h00);
      chk("illegal", 32'h1, ill);
      chk("flags", 32'h05, flags_q);
      @(posedge core_clk);
      rst_b <= 1'h0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'h1;
      #1;
      chk("pc", 32'h0, pc_q);
      chk("w", 32'h0, working_q);
      chk("ready", 32'h1, instr_ready);
      run(16'h0013, 8'h00);
      chk("pc", 32'h42, pc_q);
      chk("w", 32'h77, working_q);
      tally_and_finish();
   end
endmodule
`default_nettype wire
